// file: design/stc_pkg.sv
// Package for the sixteen-bit timer control block
package stc_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] STC_ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] STC_ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] STC_ADDR_STATUS = 8'h08;
  localparam logic [7:0] STC_ADDR_CAP1 = 8'h0C;
  localparam logic [7:0] STC_ADDR_CMP1 = 8'h10;
  localparam logic [7:0] STC_ADDR_CMP2 = 8'h14;
  localparam logic [7:0] STC_ADDR_CNT = 8'h18;
  localparam logic [7:0] STC_ADDR_ALTCNT = 8'h1C;
  localparam logic [7:0] STC_ADDR_CAP2 = 8'h20;

  // ------------------------------------------------------------
  // Reset values and fixed counter loads
  // ------------------------------------------------------------
  localparam logic [7:0] STC_CTRL_RESET = 8'h00;
  localparam logic [15:0] STC_CNT_RESET = 16'hFFFC;
  localparam logic [15:0] STC_CNT_LAST = 16'hFFFF;
  localparam logic [15:0] STC_OPM_CAPTURE = 16'hFFFD;
  localparam logic [15:0] STC_CMP_RESET = 16'h8000;
  localparam logic [15:0] STC_CAP_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Status bit positions
  // ------------------------------------------------------------
  localparam int STC_SR_CAP1 = 7;
  localparam int STC_SR_CMP1 = 6;
  localparam int STC_SR_OVF = 5;
  localparam int STC_SR_CAP2 = 4;
  localparam int STC_SR_CMP2 = 3;

  // Prescaler divide counts minus one
  localparam logic [2:0] STC_DIV2_LAST = 3'h1;
  localparam logic [2:0] STC_DIV4_LAST = 3'h3;
  localparam logic [2:0] STC_DIV8_LAST = 3'h7;

  typedef enum logic [1:0] {
    STC_CLK_DIV4,
    STC_CLK_DIV2,
    STC_CLK_DIV8,
    STC_CLK_EXT
  } stc_clksel_type;

  // Control one, bit 7 down to bit 0
  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_compare_two;
    logic force_compare_one;
    logic level_two;
    logic capture_edge_one;
    logic level_one;
  } stc_ctrl1_type;

  // Control two, bit 7 down to bit 0
  typedef struct packed {
    logic compare_pin_one_enable;
    logic compare_pin_two_enable;
    logic one_pulse_select;
    logic pwm_select;
    stc_clksel_type clock_select;
    logic capture_edge_two;
    logic ext_clock_edge;
  } stc_ctrl2_type;

  // Event flags
  typedef struct packed {
    logic capture_flag_one;
    logic compare_flag_one;
    logic overflow_flag;
    logic capture_flag_two;
    logic compare_flag_two;
  } stc_flags_type;

endpackage

// file: design/stc_timer.sv
// Sixteen-bit timer with captures, compares, one-pulse and PWM modes
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Wait state: timer runs, interrupt wakes device
// - Halt freezes registers; counter resumes afterwards
// - Halt capture edge arms flag, captured at exit
// - Flag one from capture or PWM restart
// - One request line: flag, enable, unmasked
// - No compare flags while PWM active
// - Three control/status plus six data registers
// - Capture enable gates both capture flags
// - Compare enable gates both compare flags
// - Overflow enable gates overflow flag
// - Force two copies level two to pin
// - Force one copies level one to pin
// - Level two on match two, pulse level
// - Capture edge one: zero falling, one rising
// - Level one driven on compare-one match
// - Pin one enable only routes signal
// - Pin two enable only routes signal
// - One-pulse: capture edge triggers single pulse
// - PWM: pulse from compare one, period two
// - Clock select: div4, div2, div8, external
// - Missing external pin stops counter
// - Control registers read/write, reset zero
// - PWM wins over one-pulse when both set
// - Capture edge two: zero falling, one rising
// - External clock edge: zero falling, one rising
module stc_timer
  import stc_pkg::*;
#(
  parameter bit EXT_CLOCK_PRESENT = 1'b1
) (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic capture_in_one, // First capture input
  input wire logic capture_in_two, // Second capture input
  input wire logic external_timer_clock, // External counter clock
  input wire logic halt_mode, // Processor halted
  input wire logic wait_mode, // Processor in wait
  input wire logic irq_mask, // Processor interrupt mask bit
  output logic compare_out_one, // First compare pin level
  output logic compare_oe_one, // First compare pin owned by timer
  output logic compare_out_two, // Second compare pin level
  output logic compare_oe_two, // Second compare pin owned by timer
  output logic timer_irq, // Shared timer interrupt request
  output logic wait_wake // Wake request from wait
);

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  stc_ctrl1_type ctrl1_reg;
  stc_ctrl2_type ctrl2_reg;
  stc_flags_type flags_reg;
  logic [15:0] count_reg;
  logic [15:0] cap1_reg;
  logic [15:0] cap2_reg;
  logic [15:0] cmp1_reg;
  logic [15:0] cmp2_reg;
  logic [2:0] div_reg;
  logic [2:0] ext_sync_reg;
  logic cap1_prev_reg;
  logic cap2_prev_reg;
  logic halt_prev_reg;
  logic arm1_reg;
  logic arm2_reg;
  stc_flags_type sr_seen_reg;
  logic out1_reg;
  logic out2_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic bus_done;
  logic bus_wr;
  logic bus_rd;
  logic addr_ok;

  assign bus_done = psel && penable && pready;
  assign bus_wr = bus_done && pwrite && addr_ok;
  assign bus_rd = bus_done && !pwrite && addr_ok;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  always_comb begin
    unique case (paddr)
      STC_ADDR_CTRL1, STC_ADDR_CTRL2, STC_ADDR_STATUS, STC_ADDR_CAP1,
      STC_ADDR_CMP1, STC_ADDR_CMP2, STC_ADDR_CNT, STC_ADDR_ALTCNT,
      STC_ADDR_CAP2: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Mode and tick generation
  // ------------------------------------------------------------
  logic pwm_on;
  logic opm_on;
  logic run;
  logic tick;
  logic ext_edge;
  logic [2:0] div_last;

  assign pwm_on = ctrl2_reg.pwm_select;
  assign opm_on = ctrl2_reg.one_pulse_select && !ctrl2_reg.pwm_select;
  assign run = !halt_mode;

  // Edge chosen from the synchronised second and third stages
  assign ext_edge = ctrl2_reg.ext_clock_edge ?
    (ext_sync_reg[1] && !ext_sync_reg[2]) :
    (!ext_sync_reg[1] && ext_sync_reg[2]);

  always_comb begin
    unique case (ctrl2_reg.clock_select)
      STC_CLK_DIV2: div_last = STC_DIV2_LAST;
      STC_CLK_DIV4: div_last = STC_DIV4_LAST;
      STC_CLK_DIV8: div_last = STC_DIV8_LAST;
      STC_CLK_EXT: div_last = STC_DIV8_LAST;
    endcase
  end

  // External setting ticks only when the pin exists
  assign tick = run && ((ctrl2_reg.clock_select == STC_CLK_EXT) ?
    (EXT_CLOCK_PRESENT && ext_edge) : (div_reg == div_last));

  always_ff @(posedge mclk) begin
    if (rst || !run || div_reg == div_last) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // Two-stage synchroniser, third stage for edge detect
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], external_timer_clock};
    end
  end

  // ------------------------------------------------------------
  // Capture edges, compare matches and halt exit
  // ------------------------------------------------------------
  logic edge1;
  logic edge2;
  logic halt_exit;
  logic match1;
  logic match2;
  logic ovf;
  logic opm_start;
  logic pwm_restart;
  logic cap1_evt;
  logic cap2_evt;

  assign edge1 = ctrl1_reg.capture_edge_one ?
    (capture_in_one && !cap1_prev_reg) : (!capture_in_one && cap1_prev_reg);
  assign edge2 = ctrl2_reg.capture_edge_two ?
    (capture_in_two && !cap2_prev_reg) : (!capture_in_two && cap2_prev_reg);

  assign halt_exit = halt_prev_reg && !halt_mode;
  assign match1 = tick && count_reg == cmp1_reg;
  assign match2 = tick && count_reg == cmp2_reg;
  assign ovf = tick && count_reg == STC_CNT_LAST;
  // One-pulse start on the selected first edge
  assign opm_start = run && opm_on && edge1;
  assign pwm_restart = pwm_on && match2;
  // Armed halt edges complete at halt exit
  assign cap1_evt = !pwm_on && !opm_on &&
    ((run && edge1) || (halt_exit && arm1_reg));
  assign cap2_evt = (run && edge2) || (halt_exit && arm2_reg);

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Track the pins in reset: no false edge on release
      cap1_prev_reg <= capture_in_one;
      cap2_prev_reg <= capture_in_two;
      halt_prev_reg <= 1'b0;
    end else begin
      cap1_prev_reg <= capture_in_one;
      cap2_prev_reg <= capture_in_two;
      halt_prev_reg <= halt_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || halt_exit) begin
      arm1_reg <= 1'b0;
      arm2_reg <= 1'b0;
    end else if (halt_mode) begin
      arm1_reg <= arm1_reg || (edge1 && !pwm_on);
      arm2_reg <= arm2_reg || edge2;
    end
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= STC_CNT_RESET;
    end else if (bus_wr && (hit(paddr, STC_ADDR_CNT) ||
                 hit(paddr, STC_ADDR_ALTCNT))) begin
      count_reg <= STC_CNT_RESET;
    end else if (opm_start || pwm_restart) begin
      count_reg <= STC_CNT_RESET;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Capture and compare value registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cap1_reg <= STC_CAP_RESET;
    end else if (opm_start) begin
      cap1_reg <= STC_OPM_CAPTURE;
    end else if (cap1_evt) begin
      cap1_reg <= count_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cap2_reg <= STC_CAP_RESET;
    end else if (cap2_evt) begin
      cap2_reg <= count_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp1_reg <= STC_CMP_RESET;
      cmp2_reg <= STC_CMP_RESET;
    end else if (bus_wr) begin
      if (hit(paddr, STC_ADDR_CMP1)) begin
        cmp1_reg <= pwdata[15:0];
      end
      if (hit(paddr, STC_ADDR_CMP2)) begin
        cmp2_reg <= pwdata[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Both reset to zero, full read/write
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl1_reg <= stc_ctrl1_type'(STC_CTRL_RESET);
      ctrl2_reg <= stc_ctrl2_type'(STC_CTRL_RESET);
    end else if (bus_wr) begin
      if (hit(paddr, STC_ADDR_CTRL1)) begin
        ctrl1_reg <= stc_ctrl1_type'(pwdata[7:0]);
      end
      if (hit(paddr, STC_ADDR_CTRL2)) begin
        ctrl2_reg <= stc_ctrl2_type'(pwdata[7:0]);
      end
    end
  end

  // ------------------------------------------------------------
  // Flags: set beats clear, clear needs a prior status read
  // ------------------------------------------------------------
  stc_flags_type set_now;
  stc_flags_type clr_now;
  logic acc;

  assign acc = bus_done && addr_ok;

  always_comb begin
    // Flag one from capture or PWM period end
    set_now.capture_flag_one = cap1_evt || opm_start || pwm_restart;
    set_now.capture_flag_two = cap2_evt;
    // Compare flags held off in PWM; flag one in one-pulse
    set_now.compare_flag_one = match1 && !pwm_on && !opm_on;
    set_now.compare_flag_two = match2 && !pwm_on;
    set_now.overflow_flag = ovf;
    clr_now.capture_flag_one = acc && hit(paddr, STC_ADDR_CAP1) &&
      sr_seen_reg.capture_flag_one;
    clr_now.capture_flag_two = acc && hit(paddr, STC_ADDR_CAP2) &&
      sr_seen_reg.capture_flag_two;
    clr_now.compare_flag_one = acc && hit(paddr, STC_ADDR_CMP1) &&
      sr_seen_reg.compare_flag_one;
    clr_now.compare_flag_two = acc && hit(paddr, STC_ADDR_CMP2) &&
      sr_seen_reg.compare_flag_two;
    // Alternate counter view leaves overflow alone
    clr_now.overflow_flag = acc && hit(paddr, STC_ADDR_CNT) &&
      sr_seen_reg.overflow_flag;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= set_now | (flags_reg & ~clr_now);
    end
  end

  // Status read records which flags were seen set
  always_ff @(posedge mclk) begin
    if (rst) begin
      sr_seen_reg <= '0;
    end else if (bus_rd && hit(paddr, STC_ADDR_STATUS)) begin
      sr_seen_reg <= flags_reg;
    end else begin
      sr_seen_reg <= sr_seen_reg & ~clr_now;
    end
  end

  // ------------------------------------------------------------
  // Compare output levels
  // ------------------------------------------------------------
  logic force1;
  logic force2;

  assign force1 = bus_wr && hit(paddr, STC_ADDR_CTRL1) && pwdata[3];
  assign force2 = bus_wr && hit(paddr, STC_ADDR_CTRL1) && pwdata[4];

  always_ff @(posedge mclk) begin
    if (rst) begin
      out1_reg <= 1'b0;
    end else if (pwm_on) begin
      // Pulse edge on match one, period edge on match two
      if (pwm_restart) begin
        out1_reg <= ctrl1_reg.level_two;
      end else if (match1) begin
        out1_reg <= ctrl1_reg.level_one;
      end
    end else if (opm_on) begin
      if (opm_start) begin
        out1_reg <= ctrl1_reg.level_two;
      end else if (match1) begin
        out1_reg <= ctrl1_reg.level_one;
      end
    end else if (force1) begin
      // Forced copy uses the newly written level
      out1_reg <= pwdata[0];
    end else if (match1) begin
      out1_reg <= ctrl1_reg.level_one;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out2_reg <= 1'b0;
    end else if (!pwm_on && !opm_on) begin
      if (force2) begin
        out2_reg <= pwdata[2];
      end else if (match2) begin
        out2_reg <= ctrl1_reg.level_two;
      end
    end
  end

  // Pins: internal compare runs whatever the enables say
  always_ff @(posedge mclk) begin
    if (rst) begin
      compare_out_one <= 1'b0;
      compare_out_two <= 1'b0;
      compare_oe_one <= 1'b0;
      compare_oe_two <= 1'b0;
    end else begin
      // Enable one only routes to the pin
      compare_oe_one <= ctrl2_reg.compare_pin_one_enable;
      compare_out_one <= out1_reg;
      // Enable two only routes to the pin
      compare_oe_two <= ctrl2_reg.compare_pin_two_enable;
      compare_out_two <= out2_reg;
    end
  end

  // ------------------------------------------------------------
  // Interrupt request and wait wake-up
  // ------------------------------------------------------------
  logic irq_src;

  assign irq_src =
    (ctrl1_reg.capture_irq_enable &&
     (flags_reg.capture_flag_one || flags_reg.capture_flag_two)) ||
    (ctrl1_reg.compare_irq_enable &&
     (flags_reg.compare_flag_one || flags_reg.compare_flag_two)) ||
    (ctrl1_reg.overflow_irq_enable && flags_reg.overflow_flag);

  // One shared line, gated by the processor mask
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer_irq <= 1'b0;
      wait_wake <= 1'b0;
    end else begin
      timer_irq <= irq_src && !irq_mask;
      // Wake from wait; no wake from halt
      wait_wake <= irq_src && !irq_mask && wait_mode;
    end
  end

  // ------------------------------------------------------------
  // APB slave, one wait state per transfer
  // ------------------------------------------------------------
  logic [31:0] rd_mux;

  // Control, status and six data words
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      STC_ADDR_CTRL1: rd_mux[7:0] = ctrl1_reg;
      STC_ADDR_CTRL2: rd_mux[7:0] = ctrl2_reg;
      STC_ADDR_STATUS: rd_mux[7:3] = flags_reg;
      STC_ADDR_CAP1: rd_mux[15:0] = cap1_reg;
      STC_ADDR_CMP1: rd_mux[15:0] = cmp1_reg;
      STC_ADDR_CMP2: rd_mux[15:0] = cmp2_reg;
      STC_ADDR_CNT, STC_ADDR_ALTCNT: rd_mux[15:0] = count_reg;
      STC_ADDR_CAP2: rd_mux[15:0] = cap2_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !addr_ok;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: tb/stc_timer_chk.sv
// Port checker for the timer control block, bound to its top
`timescale 1ns/10ps
`default_nettype none
module stc_timer_chk
  import stc_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic wait_mode, // Wait state
  input wire logic irq_mask, // Interrupt mask
  input wire logic compare_oe_one, // Pin one owned
  input wire logic compare_oe_two, // Pin two owned
  input wire logic timer_irq, // Request
  input wire logic wait_wake // Wake
);
  logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  mask_gate_a:
    assert property (irq_mask |=> !timer_irq)
    else $error("request raised while masked");
  wake_gate_a:
    assert property (!wait_mode |=> !wait_wake)
    else $error("wake raised outside wait");
  wake_copy_a:
    assert property (wait_mode |=> wait_wake == timer_irq)
    else $error("wake differs from request in wait");
  reset_out_a:
    assert property ($fell(rst) |-> !timer_irq && !pready
      && !compare_oe_one && prdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");
  ready_pulse_a:
    assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_time_a:
    assert property ($rose(penable) |=> pready)
    else $error("ready not in second access cycle");
  err_ready_a:
    assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
  oe_one_a:
    assert property (wr_done && paddr == STC_ADDR_CTRL2
      |-> ##2 compare_oe_one == $past(pwdata[7], 2))
    else $error("pin one ownership not from control two");
  oe_two_a:
    assert property (wr_done && paddr == STC_ADDR_CTRL2
      |-> ##2 compare_oe_two == $past(pwdata[6], 2))
    else $error("pin two ownership not from control two");
  irq_off_a:
    assert property (wr_done && paddr == STC_ADDR_CTRL1
      && pwdata[7:5] == 3'b000 |-> ##2 !timer_irq)
    else $error("request with all enables clear");
endmodule

bind stc_timer stc_timer_chk i_stc_timer_chk (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode),
  .irq_mask(irq_mask), .compare_oe_one(compare_oe_one),
  .compare_oe_two(compare_oe_two), .timer_irq(timer_irq),
  .wait_wake(wait_wake)
);
`default_nettype wire

// file: tb/stc_timer_bench.sv
// Self-checking bench for the timer control block
`timescale 1ns/10ps
`default_nettype none
module stc_timer_bench;
  import stc_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er, prev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, a;
  logic cap_one, cap_two, halt_mode, wait_mode, irq_mask, ext_clk;
  logic out_one, oe_one, out_two, oe_two, timer_irq, wait_wake;
  int err_count, n_compared, hi, rises;

  stc_timer i_stc_timer (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_in_one(cap_one),
    .capture_in_two(cap_two), .external_timer_clock(ext_clk),
    .halt_mode(halt_mode), .wait_mode(wait_mode), .irq_mask(irq_mask),
    .compare_out_one(out_one), .compare_oe_one(oe_one),
    .compare_out_two(out_two), .compare_oe_two(oe_two),
    .timer_irq(timer_irq), .wait_wake(wait_wake)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %b want %b", $time, got, exp);
    end
  endtask

  // Request held until ready is sampled; bounded wait
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n >= 50) begin
      err_count++;
      $display("CHECK FAILED at %0t: no ready", $time);
      end_of_test;
    end
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0000_0000);
    chk_word(rd, exp);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
  endtask

  task automatic done(input string s);
    $display("test %0s over, failures %0d", s, err_count);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cap_one = 1'b0;
    cap_two = 1'b0;
    ext_clk = 1'b0;
    halt_mode = 1'b0;
    wait_mode = 1'b0;
    irq_mask = 1'b1;
    err_count = 0;
    n_compared = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdc(STC_ADDR_CTRL1, 32'h0000_0000);
    rdc(STC_ADDR_CTRL2, 32'h0000_0000);
    rdc(STC_ADDR_CMP2, 32'h0000_8000);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk_bit(er, 1'b1);
    apb(1'b1, STC_ADDR_CTRL2, 32'h0000_00C0);
    rdc(STC_ADDR_CTRL2, 32'h0000_00C0);
    done("registers");
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_001D);
    idle(2);
    chk_bit(out_one, 1'b1);
    chk_bit(out_two, 1'b1);
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0018);
    idle(2);
    chk_bit(out_two, 1'b0);
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0005);
    idle(2);
    chk_bit(out_one, 1'b0);
    done("force");
    // Overflow request, mask and wait wake
    irq_mask <= 1'b0;
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0020);
    idle(2);
    chk_bit(timer_irq, 1'b1);
    wait_mode <= 1'b1;
    idle(2);
    chk_bit(wait_wake, 1'b1);
    irq_mask <= 1'b1;
    idle(2);
    chk_bit(timer_irq, 1'b0);
    irq_mask <= 1'b0;
    wait_mode <= 1'b0;
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_00C0);
    idle(2);
    chk_bit(timer_irq, 1'b0);
    // Alternate view must not clear overflow; counter view must
    rdc(STC_ADDR_STATUS, 32'h0000_0020);
    apb(1'b0, STC_ADDR_ALTCNT, 32'h0000_0000);
    rdc(STC_ADDR_STATUS, 32'h0000_0020);
    apb(1'b0, STC_ADDR_CNT, 32'h0000_0000);
    rdc(STC_ADDR_STATUS, 32'h0000_0000);
    done("interrupts");
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0002);
    apb(1'b0, STC_ADDR_CNT, 32'h0000_0000);
    a = rd;
    halt_mode <= 1'b1;
    cap_one <= 1'b1;
    idle(40);
    halt_mode <= 1'b0;
    apb(1'b0, STC_ADDR_CNT, 32'h0000_0000);
    chk_bit((rd - a) < 32'd4, 1'b1);
    rdc(STC_ADDR_STATUS, 32'h0000_0080);
    apb(1'b0, STC_ADDR_CAP1, 32'h0000_0000);
    chk_bit((rd - a) < 32'd4, 1'b1);
    done("halt");
    // Edge selection on both capture inputs
    cap_one <= 1'b0;
    cap_two <= 1'b1;
    idle(4);
    rdc(STC_ADDR_STATUS, 32'h0000_0000);
    cap_one <= 1'b1;
    cap_two <= 1'b0;
    idle(4);
    rdc(STC_ADDR_STATUS, 32'h0000_0090);
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0082);
    idle(2);
    chk_bit(timer_irq, 1'b1);
    apb(1'b0, STC_ADDR_CAP1, 32'h0000_0000);
    done("captures");
    // Repeating waveform with one-pulse also set
    apb(1'b1, STC_ADDR_CMP1, 32'h0000_0004);
    apb(1'b1, STC_ADDR_CMP2, 32'h0000_000C);
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0004);
    apb(1'b1, STC_ADDR_CTRL2, 32'h0000_00B4);
    apb(1'b1, STC_ADDR_CNT, 32'h0000_0000);
    hi = 0;
    rises = 0;
    prev = out_one;
    repeat (200) begin
      @(posedge mclk);
      hi += (out_one === 1'b1);
      rises += (out_one === 1'b1 && prev === 1'b0);
      prev = out_one;
    end
    chk_bit(rises >= 4 && rises <= 7, 1'b1);
    chk_bit(hi > 60 && hi < 130, 1'b1);
    apb(1'b0, STC_ADDR_STATUS, 32'h0000_0000);
    chk_word(rd & 32'h0000_0048, 32'h0000_0000);
    chk_bit(rd[7], 1'b1);
    done("waveform");
    // Single pulse on a rising first capture edge
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0006);
    apb(1'b1, STC_ADDR_CTRL2, 32'h0000_00A4);
    cap_one <= 1'b0;
    idle(2);
    cap_one <= 1'b1;
    idle(4);
    chk_bit(out_one, 1'b1);
    rdc(STC_ADDR_CAP1, 32'h0000_FFFD);
    idle(20);
    chk_bit(out_one, 1'b0);
    done("one pulse");
    // Divide by eight, compare flag and request
    apb(1'b1, STC_ADDR_CTRL2, 32'h0000_0008);
    apb(1'b1, STC_ADDR_CNT, 32'h0000_0000);
    idle(80);
    apb(1'b0, STC_ADDR_CNT, 32'h0000_0000);
    chk_bit(rd[15:0] == 16'h0006 || rd[15:0] == 16'h0007, 1'b1);
    apb(1'b0, STC_ADDR_STATUS, 32'h0000_0000);
    chk_word(rd & 32'h0000_0040, 32'h0000_0040);
    apb(1'b1, STC_ADDR_CTRL1, 32'h0000_0040);
    idle(2);
    chk_bit(timer_irq, 1'b1);
    done("divide");
    // External clock, rising then falling edge
    apb(1'b1, STC_ADDR_CTRL2, 32'h0000_000D);
    apb(1'b1, STC_ADDR_CNT, 32'h0000_0000);
    ext_clk <= 1'b1;
    idle(6);
    rdc(STC_ADDR_CNT, 32'h0000_FFFD);
    apb(1'b1, STC_ADDR_CTRL2, 32'h0000_000C);
    ext_clk <= 1'b0;
    idle(6);
    rdc(STC_ADDR_CNT, 32'h0000_FFFE);
    done("external");
    end_of_test;
  end
endmodule
`default_nettype wire
